// ### hw/pmlr_regs.sv
// Power management control/status and local register window of one function.
`timescale 1ns/1ps

module pmlr_regs (
  // Clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             sys_rst_i,
  // Decoded bus cycle
  input  wire pmlr_pkg::pmlr_req_t req_i,
  output logic                  ack_o,
  output logic [31:0]           rdata_o,
  // Video decoder side
  input  wire logic             field_even_i,
  input  wire logic             luma_ovf_i,
  input  wire logic             chroma_ovf_i,
  // Control outputs
  output logic [1:0]            power_state_o,
  output logic                  low_power_o,
  output logic [7:0]            input_format_o,
  output logic [7:0]            fifo_control_o,
  output logic                  fifo_flush_o,
  output logic [31:0]           active_set_o
);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Word index of a byte offset, so decode compares only AD[11:2].
  function automatic logic [11:2] word_of(input logic [11:0] off);
    word_of = off[11:2];
  endfunction

  // Merge one byte lane into a byte under an active-low enable.
  function automatic logic [7:0] lane_merge(input logic [7:0] old_v,
                                            input logic [7:0] new_v,
                                            input logic       en_n);
    lane_merge = en_n ? old_v : new_v;
  endfunction

  // True when a word index falls inside a bank of set words at base.
  function automatic logic in_bank(input logic [11:2] addr,
                                   input logic [11:2] base);
    logic [11:2] rel;
    rel     = addr - base;
    in_bank = (addr >= base) && (rel < 10'(pmlr_pkg::FIELD_REGS));
  endfunction

  // Word slot of an address inside a bank; only meaningful on a bank hit.
  function automatic logic [1:0] bank_slot(input logic [11:2] addr,
                                           input logic [11:2] base);
    logic [11:2] rel;
    rel       = addr - base;
    bank_slot = rel[3:2];
  endfunction

  // ==========================================================================
  // Request decode
  // ==========================================================================
  localparam int FIELD_REGS = pmlr_pkg::FIELD_REGS;

  logic [7:0]            stat_reg;
  logic [1:0]            pwr_state;
  logic [7:0]            in_format;
  logic [7:0]            fifo_ctrl;
  logic                  flush_pulse;
  logic [7:0]            even_set [FIELD_REGS];
  logic [7:0]            odd_set  [FIELD_REGS];
  logic [1:0]            ovf_flags;
  logic [FIELD_REGS-1:0] even_we;
  logic [FIELD_REGS-1:0] odd_we;

  // Configuration cycles only look at the dword inside the header, so the
  // upper address bits of a configuration request are ignored on purpose.
  // Window cycles compare the full word index of the 4 kB window.

  wire         cfg_acc   = req_i.valid & req_i.cfg_space;
  wire         mem_acc   = req_i.valid & ~req_i.cfg_space;
  wire         cfg_wr    = cfg_acc & req_i.write;
  wire         mem_wr    = mem_acc & req_i.write;
  wire         lane0_n   = req_i.byte_en_n[0];
  wire [7:0]   wbyte     = req_i.wdata[7:0];
  wire [11:2]  waddr     = req_i.addr;

  wire hit_pmcs   = cfg_acc & (waddr[7:2] == pmlr_pkg::PMCS_OFFSET[7:2]);
  wire hit_status = mem_acc & (waddr == word_of(pmlr_pkg::DEV_STATUS_OFF));
  wire hit_format = mem_acc & (waddr == word_of(pmlr_pkg::IN_FORMAT_OFF));
  wire hit_fifo   = mem_acc & (waddr == word_of(pmlr_pkg::FIFO_CTRL_OFF));

  // Even and odd banks sit at two aligned blocks of FIELD_REGS words.
  wire [11:2] even_base = word_of(pmlr_pkg::EVEN_SET_OFF);
  wire [11:2] odd_base  = word_of(pmlr_pkg::ODD_SET_OFF);
  wire hit_even   = mem_acc & in_bank(waddr, even_base);
  wire hit_odd    = mem_acc & in_bank(waddr, odd_base);
  wire [1:0] even_idx = bank_slot(waddr, even_base);
  wire [1:0] odd_idx  = bank_slot(waddr, odd_base);

  // ==========================================================================
  // Power management control/status
  // ==========================================================================
  // Only the two state bits are stored; every other bit is a constant, so a
  // write to them completes and has nothing to alter.
  wire [1:0] wr_state  = req_i.wdata[pmlr_pkg::PWR_STATE_LSB +: 2];
  wire       state_ok  = (wr_state == pmlr_pkg::PWR_D0) |
                         (wr_state == pmlr_pkg::PWR_D3_HOT);
  wire       pmcs_wr   = cfg_wr & hit_pmcs & ~lane0_n;
  wire       pwr_load  = pmcs_wr & state_ok;
  wire [1:0] next_pwr_state = pwr_load ? wr_state : pwr_state;

  // Read-only fields: data, scale, select, wake bits, bridge byte, reserved.
  // Wake support is absent, so both wake bits are tied low and never stored.
  wire [7:0] pwr_data_ro    = 8'h00;
  wire [7:0] bridge_ext_ro  = 8'h00;
  wire       wake_status_ro = 1'b0;
  wire [1:0] data_scale_ro  = 2'h0;
  wire [3:0] data_sel_ro    = 4'h0;
  wire       wake_enable_ro = 1'b0;
  wire [5:0] reserved_ro    = 6'h00;

  wire [31:0] pmcs_rd = {pwr_data_ro,
                         bridge_ext_ro,
                         wake_status_ro,
                         data_scale_ro,
                         data_sel_ro,
                         wake_enable_ro,
                         reserved_ro,
                         pwr_state};

  // ==========================================================================
  // Device status: live field bit and sticky overflow flags
  // ==========================================================================
  wire       stat_wr   = mem_wr & hit_status & ~lane0_n;
  wire       luma_clr   = stat_wr & wbyte[pmlr_pkg::STAT_LOF_BIT];
  wire       chroma_clr = stat_wr & wbyte[pmlr_pkg::STAT_COF_BIT];
  wire [1:0] clr_mask   = {luma_clr, chroma_clr};
  // Events are taken as one-clock strobes or levels; a level keeps the flag
  // set, so software sees it again until the source goes quiet.
  wire [1:0] set_mask  = {luma_ovf_i, chroma_ovf_i};
  // A new overflow in the clearing cycle survives the clear.
  wire [1:0] next_ovf  = (ovf_flags & ~clr_mask) | set_mask;

  always_comb begin
    stat_reg = 8'h00;
    stat_reg[pmlr_pkg::STAT_FIELD_BIT] = field_even_i;
    stat_reg[pmlr_pkg::STAT_LOF_BIT]   = ovf_flags[1];
    stat_reg[pmlr_pkg::STAT_COF_BIT]   = ovf_flags[0];
  end

  // ==========================================================================
  // Plain read/write and read/write-star registers
  // ==========================================================================
  wire fmt_wr  = mem_wr & hit_format & ~lane0_n;
  wire fifo_wr = mem_wr & hit_fifo & ~lane0_n;
  wire [7:0] next_format = lane_merge(in_format, wbyte, ~fmt_wr);

  // The flush bit acts once and is never stored, so it always reads back 0.
  wire       next_flush = fifo_wr & wbyte[pmlr_pkg::FIFO_FLUSH_BIT];
  wire [7:0] fifo_wval  = {1'b0, wbyte[6:0]};
  wire [7:0] next_fifo  = lane_merge(fifo_ctrl, fifo_wval, ~fifo_wr);

  // ==========================================================================
  // Read data mux
  // ==========================================================================
  logic [7:0]  lane0_rd;
  logic [31:0] next_rdata;

  // Bank reads are looked up once here so the mux below stays flat.
  wire [7:0] even_rd   = even_set[even_idx];
  wire [7:0] odd_rd    = odd_set[odd_idx];
  // A window hit on no register reads as zero, as does any other
  // configuration dword; zero is one of the values a reader may see.
  wire       hit_local = hit_status | hit_format | hit_fifo | hit_even | hit_odd;

  // Unmapped window addresses read as zero, which is one allowed value.
  always_comb begin
    if (hit_status) begin
      lane0_rd = stat_reg;
    end else if (hit_format) begin
      lane0_rd = in_format;
    end else if (hit_fifo) begin
      lane0_rd = fifo_ctrl;
    end else if (hit_even) begin
      lane0_rd = even_rd;
    end else if (hit_odd) begin
      lane0_rd = odd_rd;
    end else begin
      lane0_rd = 8'h00;
    end
  end

  always_comb begin
    if (hit_pmcs) begin
      next_rdata = pmcs_rd;
    end else if (hit_local) begin
      next_rdata = {24'h000000, lane0_rd};
    end else begin
      next_rdata = 32'h00000000;
    end
  end

  // ==========================================================================
  // Even/odd field register sets
  // ==========================================================================
  logic [31:0] next_active;

  always_comb begin
    next_active = 32'h00000000;
    for (int i = 0; i < FIELD_REGS; i++) begin
      // Odd field while the indication is low, even set while it is high.
      next_active[i*8 +: 8] = field_even_i ? even_set[i] : odd_set[i];
    end
  end

  // One write strobe per slot keeps the bank processes free of decode.
  always_comb begin
    even_we = '0;
    odd_we  = '0;
    for (int i = 0; i < FIELD_REGS; i++) begin
      even_we[i] = mem_wr & hit_even & ~lane0_n & (even_idx == 2'(i));
      odd_we[i]  = mem_wr & hit_odd & ~lane0_n & (odd_idx == 2'(i));
    end
  end

  // ==========================================================================
  // Bank storage
  // ==========================================================================
  // Both banks stay writable in either field, so software may prepare the
  // set not in use while the other one drives the active view.
  always_ff @(posedge ref_clk_i) begin
    for (int i = 0; i < FIELD_REGS; i++) begin
      if (sys_rst_i) begin
        even_set[i] <= pmlr_pkg::FIELD_REG_RST;
      end else if (even_we[i]) begin
        even_set[i] <= wbyte;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    for (int i = 0; i < FIELD_REGS; i++) begin
      if (sys_rst_i) begin
        odd_set[i] <= pmlr_pkg::FIELD_REG_RST;
      end else if (odd_we[i]) begin
        odd_set[i] <= wbyte;
      end
    end
  end

  // ==========================================================================
  // State registers
  // ==========================================================================
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      pwr_state <= pmlr_pkg::PWR_STATE_RST;
    end else begin
      pwr_state <= next_pwr_state;
    end
  end

  // ==========================================================================
  // Status and control registers
  // ==========================================================================
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ovf_flags <= 2'h0;
    end else begin
      ovf_flags <= next_ovf;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      in_format <= pmlr_pkg::IN_FORMAT_RST;
    end else begin
      in_format <= next_format;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      fifo_ctrl <= pmlr_pkg::FIFO_CTRL_RST;
    end else begin
      fifo_ctrl <= next_fifo;
    end
  end

  // ==========================================================================
  // Bus answer
  // ==========================================================================
  // Every request answers one cycle later; there is no retry or wait, so a
  // host may issue requests back to back in any power state.
  wire        next_ack   = req_i.valid;
  wire        rd_take    = req_i.valid & ~req_i.write;
  // Read data sits at zero outside its answer cycle, so a stale word can
  // never pass for a fresh one.
  wire [31:0] next_rword = rd_take ? next_rdata : 32'h00000000;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= next_ack;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rdata_o <= 32'h00000000;
    end else begin
      rdata_o <= next_rword;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      flush_pulse <= 1'b0;
    end else begin
      flush_pulse <= next_flush;
    end
  end

  // The active view lags the field indication by one clock, which keeps the
  // control outputs glitch free when the field changes.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      active_set_o <= 32'h00000000;
    end else begin
      active_set_o <= next_active;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // The low power flag is decoded from the stored state rather than kept
  // apart, so the two can never disagree.
  assign power_state_o  = pwr_state;
  assign low_power_o    = (pwr_state == pmlr_pkg::PWR_D3_HOT);
  assign input_format_o = in_format;
  assign fifo_control_o = fifo_ctrl;
  assign fifo_flush_o   = flush_pulse;

endmodule

// ### hw/pmlr_pkg.sv
// Package holding constants and types for the power and local register block.
package pmlr_pkg;

  // ==========================================================================
  // Configuration space
  // ==========================================================================
  localparam logic [11:0] PMCS_OFFSET     = 12'h050;
  localparam int          PWR_STATE_LSB   = 0;
  localparam logic [1:0]  PWR_D0          = 2'h0;
  localparam logic [1:0]  PWR_D1          = 2'h1;
  localparam logic [1:0]  PWR_D2          = 2'h2;
  localparam logic [1:0]  PWR_D3_HOT      = 2'h3;
  localparam logic [1:0]  PWR_STATE_RST   = 2'h0;

  // ==========================================================================
  // Local register window, byte offsets
  // ==========================================================================
  localparam logic [11:0] DEV_STATUS_OFF  = 12'h000;
  localparam logic [11:0] IN_FORMAT_OFF   = 12'h004;
  localparam logic [11:0] FIFO_CTRL_OFF   = 12'h030;
  localparam logic [11:0] EVEN_SET_OFF    = 12'h010;
  localparam logic [11:0] ODD_SET_OFF     = 12'h090;
  localparam int          FIELD_REGS      = 4;

  // Field positions and reset values.
  localparam int          STAT_FIELD_BIT  = 5;
  localparam int          STAT_LOF_BIT    = 1;
  localparam int          STAT_COF_BIT    = 0;
  localparam logic [7:0]  IN_FORMAT_RST   = 8'h58;
  localparam logic [7:0]  FIFO_CTRL_RST   = 8'h00;
  localparam int          FIFO_FLUSH_BIT  = 7;
  localparam logic [7:0]  FIELD_REG_RST   = 8'h00;

  // ==========================================================================
  // Request carried from the bus target front end
  // ==========================================================================
  typedef struct packed {
    logic        valid;
    logic        cfg_space;
    logic        write;
    logic [11:2] addr;
    logic [3:0]  byte_en_n;
    logic [31:0] wdata;
  } pmlr_req_t;

endpackage

// ### test/pmlr_regs_props.sv
// Checker of bus answer timing and power/control register relations.
`timescale 1ns/1ps
module pmlr_regs_props (
  // Clock and reset
  input wire logic                ref_clk_i,
  input wire logic                sys_rst_i,
  // Bus and controls
  input wire pmlr_pkg::pmlr_req_t req_i,
  input wire logic                ack_o,
  input wire logic [31:0]         rdata_o,
  input wire logic [1:0]          power_state_o,
  input wire logic                low_power_o,
  input wire logic [7:0]          fifo_control_o,
  input wire logic                fifo_flush_o
);
  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  wire pm_wr = req_i.valid && req_i.cfg_space && req_i.write && !req_i.byte_en_n[0]
               && req_i.addr == pmlr_pkg::PMCS_OFFSET[11:2];
  wire fl_wr = req_i.valid && !req_i.cfg_space && req_i.write && !req_i.byte_en_n[0]
               && req_i.addr == pmlr_pkg::FIFO_CTRL_OFF[11:2] && req_i.wdata[7];
  AST_ACK_ONE: assert property (req_i.valid |=> ack_o)
    else $error("no answer one cycle after a request");
  AST_ACK_ONLY: assert property (!req_i.valid |=> !ack_o)
    else $error("answer without a request");
  AST_LOW_PWR: assert property (low_power_o == (power_state_o == 2'h3))
    else $error("low power flag disagrees with state");
  AST_PS_KEEP: assert property (pm_wr && req_i.wdata[0] != req_i.wdata[1] |=> $stable(power_state_o))
    else $error("unsupported state was stored");
  AST_PS_TAKE: assert property (pm_wr && req_i.wdata[0] == req_i.wdata[1]
    |=> power_state_o == $past(req_i.wdata[1:0]))
    else $error("supported state not stored");
  AST_CFG_RO: assert property (req_i.valid && req_i.cfg_space && !req_i.write
    |=> rdata_o[31:2] == 30'h0)
    else $error("fixed config bits not zero");
  AST_LANE0: assert property (req_i.valid && !req_i.cfg_space && !req_i.write
    |=> rdata_o[31:8] == 24'h0)
    else $error("upper lanes not zero");
  AST_FLUSH_RD: assert property (fifo_control_o[7] == 1'b0)
    else $error("flush bit stored");
  AST_FLUSH: assert property (fl_wr |=> fifo_flush_o ##1 !fifo_flush_o)
    else $error("flush pulse wrong");
endmodule

// ### test/pmlr_host.sv
// Host bridge model issuing one-cycle decoded bus requests.
`timescale 1ns/1ps
module pmlr_host (
  // Clock
  input wire logic                ref_clk_i,
  // Bus cycle
  output pmlr_pkg::pmlr_req_t     req_o,
  input wire logic                ack_i,
  input wire logic [31:0]         rdata_i
);
  initial req_o = '0;
  // A released request carries inverted payload so stale values never match.
  task automatic xfer(input logic c, w, input logic [11:0] a, input logic [3:0] ben,
                      input logic [31:0] d, output logic [31:0] q, output logic ok);
    int n;
    @(posedge ref_clk_i);
    req_o <= '{1'b1, c, w, a[11:2], ben, d};
    @(posedge ref_clk_i);
    req_o <= '{1'b0, c, w, ~a[11:2], ~ben, ~d};
    ok = 1'b0;
    for (n = 0; n < 8 && !ok; n++) begin
      @(posedge ref_clk_i);
      ok = (ack_i === 1'b1);
      q = rdata_i;
    end
  endtask
endmodule

// ### test/tb_top.sv
// Self-checking bench for the power state and local register block.
`timescale 1ns/1ps
module tb_top;
  logic                ref_clk_i, sys_rst_i, field_even_i, luma_ovf_i, chroma_ovf_i;
  pmlr_pkg::pmlr_req_t req;
  logic                ack, low_pwr, flush, ok;
  logic [1:0]          pstate, ps;
  logic [7:0]          ifmt, fctl, fm;
  logic [31:0]         rdata, aset, q, v;
  logic [7:0]          ev [4];
  logic [7:0]          od [4];
  integer              seed, miscompares, check_count, i;
  pmlr_regs uut (.ref_clk_i, .sys_rst_i, .req_i(req), .ack_o(ack), .rdata_o(rdata),
    .field_even_i, .luma_ovf_i, .chroma_ovf_i, .power_state_o(pstate), .low_power_o(low_pwr),
    .input_format_o(ifmt), .fifo_control_o(fctl), .fifo_flush_o(flush), .active_set_o(aset));
  pmlr_host host (.ref_clk_i, .req_o(req), .ack_i(ack), .rdata_i(rdata));
  initial begin
    ref_clk_i = 0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic chk(input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    if (miscompares == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic bus(input logic c, w, input logic [11:0] a, input logic [3:0] ben,
                     input logic [31:0] d);
    host.xfer(c, w, a, ben, d, q, ok);
    if (ok !== 1'b1) begin
      miscompares++;
      give_verdict();
    end
  endtask
  function automatic logic [1:0] next_ps(logic [1:0] cur, logic [1:0] w, logic be0_n);
    return (be0_n || w == 2'h1 || w == 2'h2) ? cur : w;
  endfunction
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  initial begin
    seed = 59;
    miscompares = 0;
    check_count = 0;
    sys_rst_i = 1;
    {field_even_i, luma_ovf_i, chroma_ovf_i} = 3'h0;
    ps = 2'h0;
    fm = pmlr_pkg::IN_FORMAT_RST;
    repeat (12) @(posedge ref_clk_i);
    sys_rst_i <= 0;
    @(posedge ref_clk_i);
    chk({pstate, low_pwr, fctl, flush}, 32'h0);
    chk(ifmt, pmlr_pkg::IN_FORMAT_RST);
    chk(aset, 32'h0);
    // Counter walks all four state codes three times, once with lane 0 disabled.
    for (i = 0; i < 12; i++) begin
      v = $random(seed);
      v[1:0] = i[1:0];
      v[4] = i[2];
      bus(1, 1, pmlr_pkg::PMCS_OFFSET, v[7:4], v);
      ps = next_ps(ps, v[1:0], v[4]);
      chk(pstate, ps);
      chk(low_pwr, ps == 2'h3);
      bus(1, 0, pmlr_pkg::PMCS_OFFSET, 4'h0, 0);
      chk(q, {30'h0, ps});
    end
    for (i = 0; i < 6; i++) begin
      v = $random(seed);
      bus(0, 1, pmlr_pkg::IN_FORMAT_OFF, v[11:8], v);
      if (!v[8]) fm = v[7:0];
      chk(ifmt, fm);
      bus(0, 0, pmlr_pkg::IN_FORMAT_OFF, v[15:12], 0);
      chk(q, {24'h0, fm});
    end
    bus(0, 1, pmlr_pkg::FIFO_CTRL_OFF, 4'h0, 32'hffff_ffff);
    chk(fctl, 8'h7f);
    bus(0, 0, 12'hffc, 4'h0, 0);
    for (i = 0; i < 4; i++) begin
      v = $random(seed);
      ev[i] = v[7:0];
      od[i] = v[15:8];
      bus(0, 1, pmlr_pkg::EVEN_SET_OFF + 12'(4 * i), 4'h0, {24'h0, ev[i]});
      bus(0, 1, pmlr_pkg::ODD_SET_OFF + 12'(4 * i), 4'h0, {24'h0, od[i]});
    end
    repeat (2) @(posedge ref_clk_i);
    chk(aset, {od[3], od[2], od[1], od[0]});
    field_even_i <= 1;
    {luma_ovf_i, chroma_ovf_i} <= 2'h3;
    repeat (2) @(posedge ref_clk_i);
    {luma_ovf_i, chroma_ovf_i} <= 2'h0;
    chk(aset, {ev[3], ev[2], ev[1], ev[0]});
    bus(0, 1, pmlr_pkg::DEV_STATUS_OFF, 4'h0, 32'h0);
    bus(0, 0, pmlr_pkg::DEV_STATUS_OFF, 4'h0, 0);
    chk(q, 32'h23);
    bus(0, 1, pmlr_pkg::DEV_STATUS_OFF, 4'h0, 32'h1);
    bus(0, 0, pmlr_pkg::DEV_STATUS_OFF, 4'h0, 0);
    chk(q, 32'h22);
    sys_rst_i <= 1;
    repeat (2) @(posedge ref_clk_i);
    sys_rst_i <= 0;
    chk({pstate, ifmt}, {2'h0, pmlr_pkg::IN_FORMAT_RST});
    give_verdict();
  end
endmodule
bind pmlr_regs pmlr_regs_props u_props (.ref_clk_i, .sys_rst_i, .req_i, .ack_o, .rdata_o,
  .power_state_o, .low_power_o, .fifo_control_o, .fifo_flush_o);
